//--- logic/vfir_consts.svh
// constants of the 2d fir stream filter
// Functional notes
// - output trails its input by taps minus one lines plus a few cycles.
// - that latency holds only while the downstream ready stays high.
// - all state changes on the rising edge of the one clock.
// - reset takes effect at once, without a clock edge.
// - sink ready is high only when a beat can be taken.
// - source valid is high in every cycle an output beat is shown.
// - the first beat of each packet carries the start marker.
// - the last beat of each packet carries the end marker.
// - pixels come in on the sink data bus and leave on the source data bus.
`ifndef VFIR_CONSTS_SVH
`define VFIR_CONSTS_SVH
`define VFIR_TAPS       3
`define VFIR_DATA_W     8
`define VFIR_COEF_W     8
`define VFIR_LINE_LEN   640
`define VFIR_SHIFT      3
`define VFIR_FIFO_DEPTH 32
`define VFIR_SKID       5
`define VFIR_PIPE_LAT   3
`endif

//--- logic/vfir_pkg.sv
// types of the 2d fir stream filter
package vfir_pkg;
   typedef enum logic [0:0] {
      VFIR_FILL = 1'b0,
      VFIR_EMIT = 1'b1
   } vfir_phase_t;
endpackage

//--- logic/vfir_filter.sv
// 2d fir stream filter with its output fifo
`timescale 1ns/1ps
`include "vfir_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module vfir_fifo #(
   parameter int W     = 10,
   parameter int DEPTH = `VFIR_FIFO_DEPTH
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_rst_n,
   input  wire logic                     i_valid,
   output logic                          o_ready,
   input  wire logic [W-1:0]             i_data,
   output logic                          o_valid,
   input  wire logic                     i_ready,
   output logic [W-1:0]                  o_data,
   output logic [$clog2(DEPTH):0]        o_level
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          load;

   if (DEPTH < 8 || (1 << AW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two, at least 8");
   end

   assign o_ready = (cnt_r != (AW+1)'(DEPTH));
   assign push    = i_valid & o_ready;
   assign load    = (cnt_r != '0) & (~o_valid | i_ready);
   assign o_level = cnt_r;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_r] <= i_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         wr_r  <= wr_r + AW'(push);
         rd_r  <= rd_r + AW'(load);
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
      end
   end

   // output register, so the port pins come from flops
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
         o_data  <= '0;
      end else if (load) begin
         o_valid <= 1'b1;
         o_data  <= mem[rd_r];
      end else if (i_ready) begin
         o_valid <= 1'b0;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module vfir_filter
   import vfir_pkg::*;
#(
   parameter int N        = `VFIR_TAPS,
   parameter int DW       = `VFIR_DATA_W,
   parameter int CW       = `VFIR_COEF_W,
   parameter int LINE_LEN = `VFIR_LINE_LEN,
   parameter int SHIFT    = `VFIR_SHIFT,
   parameter int DEPTH    = `VFIR_FIFO_DEPTH,
   parameter logic [N*N*CW-1:0] COEFS = {(N*N){CW'(1)}}
) (
   input  wire logic          I_CLOCK,
   input  wire logic          I_RST_N,
   input  wire logic [DW-1:0] I_DATA,
   input  wire logic          I_VALID,
   input  wire logic          I_SOP,
   input  wire logic          I_EOP,
   output logic               O_READY,
   output logic [DW-1:0]      O_DATA,
   output logic               O_VALID,
   output logic               O_SOP,
   output logic               O_EOP,
   input  wire logic          I_READY
);
   localparam int CLW = $clog2(LINE_LEN);
   localparam int RW  = $clog2(N) + 1;
   localparam int AW  = $clog2(DEPTH);
   localparam int SW  = DW + CW + $clog2(N*N) + 2;

   if (N < 2 || LINE_LEN < N || SHIFT >= SW || DEPTH < 8) begin : g_chk
      $error("vfir_filter parameters out of range");
   end

   logic                accept;
   logic [CLW-1:0]      col_r;
   logic [RW-1:0]       row_r;
   vfir_phase_t         phase_r;
   logic                first_r;
   logic [DW-1:0]       lb_mem [N-1][LINE_LEN];
   logic [DW-1:0]       tap [N];
   logic [DW-1:0]       win_r [N][N];
   logic                s1_v_r;
   logic                s1_sop_r;
   logic                s1_eop_r;
   logic signed [SW-1:0] prod [N*N];
   logic signed [SW-1:0] sum;
   logic [DW-1:0]       pix_nxt;
   logic                s2_v_r;
   logic [DW+1:0]       s2_r;
   logic                f_ready;
   logic [AW:0]         f_level;
   logic                rdy_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // sink side: credit based ready
   assign accept = I_VALID & O_READY;

   // ready only while the fifo still has room for every beat in flight
   assign rdy_nxt = f_ready & (f_level <= (AW+1)'(DEPTH - `VFIR_SKID));

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_READY <= 1'b0;
      end else begin
         O_READY <= rdy_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // raster position; the first n-1 lines only fill the line stores
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         col_r   <= '0;
         row_r   <= '0;
         phase_r <= VFIR_FILL;
      end else if (accept) begin
         if (I_SOP) begin
            col_r   <= (LINE_LEN == 1) ? '0 : CLW'(1);
            row_r   <= (LINE_LEN == 1) ? RW'(1) : '0;
            phase_r <= VFIR_FILL;
         end else if (col_r == CLW'(LINE_LEN - 1)) begin
            col_r <= '0;
            unique case (phase_r)
               VFIR_FILL: begin
                  row_r <= row_r + RW'(1);
                  if (row_r == RW'(N - 2)) begin
                     phase_r <= VFIR_EMIT;
                  end
               end
               VFIR_EMIT: begin
                  row_r <= row_r;
               end
            endcase
         end else begin
            col_r <= col_r + CLW'(1);
         end
      end
   end

   // start marker waits for the first emitted beat of the packet
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         first_r <= 1'b0;
      end else if (accept && I_SOP) begin
         first_r <= 1'b1;
      end else if (accept && phase_r == VFIR_EMIT) begin
         first_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line stores and window
   assign tap[0] = I_DATA;

   for (genvar k = 0; k < N - 1; k++) begin : g_line
      assign tap[k+1] = lb_mem[k][I_SOP ? '0 : col_r];
      always_ff @(posedge I_CLOCK) begin
         if (accept) begin
            lb_mem[k][I_SOP ? '0 : col_r] <= tap[k];
         end
      end
   end

   for (genvar r = 0; r < N; r++) begin : g_win
      always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
         if (!I_RST_N) begin
            for (int c = 0; c < N; c++) begin
               win_r[r][c] <= '0;
            end
         end else if (accept) begin
            win_r[r][0] <= tap[r];
            for (int c = 1; c < N; c++) begin
               win_r[r][c] <= win_r[r][c-1];
            end
         end
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         s1_v_r   <= 1'b0;
         s1_sop_r <= 1'b0;
         s1_eop_r <= 1'b0;
      end else begin
         s1_v_r   <= accept & (phase_r == VFIR_EMIT) & ~I_SOP;
         s1_sop_r <= first_r;
         s1_eop_r <= I_EOP;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // weighted sum, rounded down by SHIFT and clamped to the pixel range
   for (genvar i = 0; i < N*N; i++) begin : g_mac
      assign prod[i] = SW'(signed'({1'b0, win_r[i/N][i%N]}))
                     * SW'(signed'(COEFS[i*CW +: CW]));
   end

   always_comb begin
      sum = '0;
      for (int i = 0; i < N*N; i++) begin
         sum = sum + prod[i];
      end
      sum = sum >>> SHIFT;
      if (sum < 0) begin
         pix_nxt = '0;
      end else if (sum > SW'((1 << DW) - 1)) begin
         pix_nxt = '1;
      end else begin
         pix_nxt = sum[DW-1:0];
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         s2_v_r <= 1'b0;
         s2_r   <= '0;
      end else begin
         s2_v_r <= s1_v_r;
         s2_r   <= {s1_sop_r, s1_eop_r, pix_nxt};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output fifo drives the source port from its output register
   vfir_fifo #(
      .W     (DW + 2),
      .DEPTH (DEPTH)
   ) u_fifo (
      .i_clk   (I_CLOCK),
      .i_rst_n (I_RST_N),
      .i_valid (s2_v_r),
      .o_ready (f_ready),
      .i_data  (s2_r),
      .o_valid (O_VALID),
      .i_ready (I_READY),
      .o_data  ({O_SOP, O_EOP, O_DATA}),
      .o_level (f_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_N);

   a_ready_room: assert property (O_READY |->
         $past(f_level) <= (AW+1)'(DEPTH - `VFIR_SKID))
      else $error("sink ready raised with fifo nearly full");
   a_push_room: assert property (s2_v_r |-> f_ready)
      else $error("beat pushed into full fifo");
   a_out_hold: assert property (O_VALID && !I_READY |=>
         O_VALID && $stable(O_DATA) && $stable(O_SOP) && $stable(O_EOP))
      else $error("output beat changed before it was taken");
   // taken at one edge, valid set three edges later, so seen at the fourth
   a_emit_latency: assert property (accept && phase_r == VFIR_EMIT && !I_SOP
         && f_level == '0 |-> ##4 O_VALID)
      else $error("emitted beat late at the source port");
   a_fill_silent: assert property (accept && phase_r == VFIR_FILL |=> !s1_v_r)
      else $error("beat emitted while lines still fill");
   a_eop_carry: assert property (accept && I_EOP && !I_SOP
         && phase_r == VFIR_EMIT |-> ##2 (s2_v_r && s2_r[DW]))
      else $error("end marker lost in the pipe");
   a_sop_carry: assert property (accept && phase_r == VFIR_EMIT && !I_SOP
         && first_r |-> ##2 (s2_v_r && s2_r[DW+1]))
      else $error("start marker missing on first output");
   a_valid_src: assert property ($rose(O_VALID) |-> $past(f_level) != '0)
      else $error("source valid without a stored beat");
   a_line_store: assert property (accept && !I_SOP && col_r == '0 |=>
         lb_mem[0][0] == $past(I_DATA))
      else $error("line store missed an input pixel");

   c_emit_beat: cover property (accept && phase_r == VFIR_EMIT);
   c_backpress: cover property ((O_VALID && !I_READY) [*4]);
   c_sink_stall: cover property (I_VALID && !O_READY);
   c_eop_out: cover property (O_VALID && I_READY && O_EOP);
endmodule

//--- sim/vfir_sink_model.sv
// downstream receiver model for the fir stream filter
`timescale 1ns/1ps
module vfir_sink_model (
   input  wire logic       i_clk,
   input  wire logic [1:0] i_mode,
   input  wire logic       i_valid,
   input  wire logic [7:0] i_data,
   input  wire logic       i_sop,
   input  wire logic       i_eop,
   output logic            o_ready
);
   logic [9:0] got_q[$];
   int         cyc;
   int         first_cyc;
   int         hold_errs;
   logic       v_s;
   logic       stalled;
   logic [9:0] b_s;
   logic [9:0] held;
   initial begin
      o_ready = 1'b0;
      cyc = 0;
      first_cyc = 0;
      hold_errs = 0;
      stalled = 1'b0;
      v_s = 1'b0;
   end
   // outputs are registered, so the value between edges is the one taken
   always @(negedge i_clk) begin
      v_s = i_valid;
      b_s = {i_sop, i_eop, i_data};
      if (v_s && stalled && b_s !== held) hold_errs++;
      if (v_s && i_sop && first_cyc == 0) first_cyc = cyc;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (v_s && o_ready) got_q.push_back(b_s);
      stalled = v_s && !o_ready;
      held = b_s;
      #1;
      // mode 0 always ready, 1 stalled, 2 ready every other cycle
      case (i_mode)
         2'h0: o_ready = 1'b1;
         2'h1: o_ready = 1'b0;
         default: o_ready = cyc[0];
      endcase
   end
endmodule

//--- sim/tb.sv
// self-checking bench of the fir stream filter
`timescale 1ns/1ps
module tb;
   localparam int LL = 8;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] i_data = 8'h00;
   logic       i_valid = 1'b0;
   logic       i_sop = 1'b0;
   logic       i_eop = 1'b0;
   logic       o_ready;
   logic [7:0] o_data;
   logic       o_valid;
   logic       o_sop;
   logic       o_eop;
   logic       s_ready;
   logic [1:0] mode = 2'h0;
   int         mismatches = 0;
   int         checks = 0;
   int         tmo = 0;
   int         take0;
   always #20 clk = ~clk;
   vfir_filter #(.LINE_LEN(LL)) dut_u (
      .I_CLOCK(clk), .I_RST_N(rst_n), .I_DATA(i_data), .I_VALID(i_valid),
      .I_SOP(i_sop), .I_EOP(i_eop), .O_READY(o_ready), .O_DATA(o_data),
      .O_VALID(o_valid), .O_SOP(o_sop), .O_EOP(o_eop), .I_READY(s_ready)
   );
   vfir_sink_model model_u (
      .i_clk(clk), .i_mode(mode), .i_valid(o_valid), .i_data(o_data),
      .i_sop(o_sop), .i_eop(o_eop), .o_ready(s_ready)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      tmo++;
      if (tmo > 20000) begin
         mismatches++;
         test_done();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // one packet, beats back to back whenever the filter is ready
   task automatic send_pkt(input int lines, input logic [7:0] v);
      logic r;
      // start off the sampling edge so the first beat never races it
      @(posedge clk);
      #1;
      for (int n = 0; n < lines * LL; n++) begin
         i_data = v;
         i_valid = 1'b1;
         i_sop = (n == 0);
         i_eop = (n == lines * LL - 1);
         do begin
            @(negedge clk);
            r = o_ready;
            @(posedge clk);
         end while (r !== 1'b1);
         #1;
         if (n == 0) take0 = model_u.cyc;
      end
      i_valid = 1'b0;
      i_data = ~v;
      i_sop = 1'b0;
      i_eop = 1'b0;
   endtask
   task automatic check_out(input int lines, input logic [7:0] f);
      logic [9:0] b;
      for (int w = 0; w < 400 && model_u.got_q.size() < (lines - 2) * LL; w++) @(posedge clk);
      repeat (20) @(posedge clk);
      check("out count", (lines - 2) * LL, model_u.got_q.size());
      for (int k = 0; k < model_u.got_q.size(); k++) begin
         b = model_u.got_q[k];
         // edge columns may use stale pixels, so only full windows are valued
         if (k % LL >= 2) check("out data", f, b[7:0]);
         check("out sop", k == 0, b[9]);
         check("out eop", k == (lines - 2) * LL - 1, b[8]);
      end
      model_u.got_q.delete();
      check("held beat", 0, model_u.hold_errs);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_short();
      send_pkt(2, 8'h10);
      repeat (30) @(posedge clk);
      check("fill only output", 0, model_u.got_q.size());
   endtask
   task automatic t_latency();
      model_u.first_cyc = 0;
      send_pkt(4, 8'h08);
      check_out(4, 8'h09);
      check("latency", 2 * LL + 3, model_u.first_cyc - take0);
   endtask
   task automatic t_stall();
      logic seen;
      seen = 1'b0;
      mode = 2'h1;
      fork
         send_pkt(6, 8'hC8);
      join_none
      for (int w = 0; w < 200 && !seen; w++) begin
         @(negedge clk);
         seen = (o_ready === 1'b0);
      end
      check("ready dropped", 1, seen);
      check("taken while stalled", 0, model_u.got_q.size());
      #1 mode = 2'h2;
      wait fork;
      check_out(6, 8'hE1);
   endtask
   task automatic t_reset();
      mode = 2'h1;
      send_pkt(3, 8'h08);
      repeat (10) @(posedge clk);
      check("pending valid", 1, o_valid);
      #1 rst_n = 1'b0;
      #1;
      check("reset outputs", 0, {o_ready, o_valid, o_sop, o_eop, o_data});
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      @(negedge clk);
      check("ready first edge", 0, o_ready);
      @(negedge clk);
      check("ready second edge", 1, o_ready);
      model_u.got_q.delete();
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      t_short();
      t_latency();
      t_stall();
      t_reset();
      test_done();
   end
endmodule
